// ===== reset_source_pkg.sv
// Package: register map, field layout, reset values and timing counts for reset source control
package reset_source_pkg;

    localparam logic [7:0] GUARD_NOP_A = 8'h55;
    localparam logic [7:0] GUARD_NOP_B = 8'hAA;
    localparam logic [7:0] GUARD_WORD_POR = 8'h55;
    localparam logic [7:0] THRESH_POR = 8'h55;
    localparam logic [7:0] THRESH_2V10 = 8'h55;
    localparam logic [7:0] THRESH_2V55 = 8'h33;
    localparam logic [7:0] THRESH_3V15 = 8'h99;
    localparam logic [7:0] THRESH_3V80 = 8'hAA;
    localparam logic [4:0] WDG_DISABLE = 5'h15;
    localparam logic [4:0] WDG_ENABLE = 5'h0A;
    localparam logic [7:0] WDG_CTRL_POR = 8'h53;

    localparam int FLAG_WATCHDOG_GUARD = 0;
    localparam int FLAG_THRESH_CORRUPT = 1;
    localparam int FLAG_LOW_VOLTAGE = 2;
    localparam int FLAG_GUARD_WORD = 3;
    localparam int STAT_TIMEOUT = 0;
    localparam int STAT_POWER_DOWN = 1;
    localparam int IRQ_GUARD_WORD = 0;
    localparam int IRQ_THRESH = 1;
    localparam int IRQ_WATCHDOG_GUARD = 2;
    localparam int IRQ_LOW_VOLTAGE = 3;
    localparam int IRQ_WDT_TIMEOUT = 4;
    localparam int IRQ_BITS = 5;

    localparam logic [7:0] OFF_GUARD_WORD = 8'h00;
    localparam logic [7:0] OFF_CAUSE_FLAGS = 8'h04;
    localparam logic [7:0] OFF_THRESH_SEL = 8'h08;
    localparam logic [7:0] OFF_WDG_CTRL = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    localparam int CLK_MHZ = 100;
    localparam int SRESET_DELAY_US = 50;
    localparam int LV_QUALIFY_US = 100;
    localparam int SRESET_CYCLES = SRESET_DELAY_US * CLK_MHZ;
    localparam int LV_QUALIFY_CYCLES = LV_QUALIFY_US * CLK_MHZ;
    localparam int RESET_PULSE_CYCLES = 4;

    typedef enum logic [1:0] {
        RST_NONE = 2'b00,
        RST_FULL = 2'b01,
        RST_CORE = 2'b11
    } reset_kind_t;

endpackage

// ===== delay_count_if.sv
// Interface: start/expire handshake between the sequencer and its delay counter
`timescale 1ns/1ps
`default_nettype none
interface delay_count_if;
    logic run;
    logic expired;
    modport ctrl (output run, input expired);
    modport timer (input run, output expired);
endinterface
`default_nettype wire

// ===== delay_counter.sv
// Delay counter: counts while run is high, restarts when run drops
`timescale 1ns/1ps
`default_nettype none
module delay_counter #(
    parameter int CYCLES = 5000
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    delay_count_if.timer dc
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] cnt_r;
    logic done_r;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (clk_en_i) begin
            if (!dc.run) begin
                cnt_r <= '0;
                done_r <= 1'b0;
            end else if (!done_r) begin
                done_r <= (cnt_r == LAST);
                cnt_r <= cnt_r + W'(1);
            end
        end
    end
    assign dc.expired = done_r;
endmodule
`default_nettype wire

// ===== reset_source_control.sv
// Reset source control: guard words, threshold selector, cause flags and reset effects
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Guard word 0x55 or 0xAA is idle; any other value resets the device after the software delay.
// - A guard-word triggered reset sets cause flag bit 3.
// - Cause flags are set only by their event and cleared only by software writing zero.
// - Cause flag bits 7 to 4 always read zero.
// - Low supply must persist past the qualification time to reset and set the low-voltage flag.
// - Selector codes 0x55, 0x33, 0x99, 0xAA pick 2.1V, 2.55V, 3.15V and 3.8V thresholds.
// - An undefined selector resets after the delay, sets its flag and reloads the power-on value.
// - A genuine low-voltage reset keeps the selector contents.
// - Low voltage reset is off in SLEEP or IDLE mode.
// - The selector powers up at 0x55.
// - A watchdog time-out in FAST or SLOW mode is a full reset that also sets the time-out flag.
// - A watchdog time-out in SLEEP or IDLE only clears PC and SP and sets the time-out and power-down flags.
// - Power-on clears TO and POWER_DOWN_STATUS_FLAG; LOW_VOLTAGE_RESET keeps both; normal timeout sets TO; low-power timeout sets both.
// - Power-on zeroes PC, disables interrupts, clears watchdog, stops timers, inputs ports, tops stack.
// - Watchdog guard 0x15 disables, 0x0A enables; other values reset after the delay and set a flag.
// - The guard word powers up at 0x55.
module reset_source_control #(
    parameter int SRESET_CYCLES = reset_source_pkg::SRESET_CYCLES,
    parameter int LV_QUALIFY_CYCLES = reset_source_pkg::LV_QUALIFY_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_supply_i,
    input wire logic low_power_mode_i,
    input wire logic wdt_timeout_i,
    input wire logic power_down_set_i,
    output logic [1:0] threshold_level_o,
    output logic low_voltage_enable_o,
    output logic watchdog_enable_o,
    output logic full_reset_o,
    output logic core_reset_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] lv_sync_r, to_sync_r;
    logic lv_s, to_s, to_prev_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lv_sync_r <= 2'b00;
            to_sync_r <= 2'b00;
        end else if (clk_en_i) begin
            lv_sync_r <= {lv_sync_r[0], low_supply_i};
            to_sync_r <= {to_sync_r[0], wdt_timeout_i};
        end
    end
    assign lv_s = lv_sync_r[1];
    assign to_s = to_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] guard_r, thresh_r, wdg_r;
    logic [3:0] cause_r;
    logic [1:0] stat_r;
    logic [reset_source_pkg::IRQ_BITS-1:0] irq_stat_r, irq_mask_r;
    logic [3:0] pulse_r;
    reset_source_pkg::reset_kind_t kind_r;

    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire sel_guard = paddr == reset_source_pkg::OFF_GUARD_WORD;
    wire sel_cause = paddr == reset_source_pkg::OFF_CAUSE_FLAGS;
    wire sel_thresh = paddr == reset_source_pkg::OFF_THRESH_SEL;
    wire sel_wdg = paddr == reset_source_pkg::OFF_WDG_CTRL;
    wire sel_stat = paddr == reset_source_pkg::OFF_STATUS;
    wire sel_istat = paddr == reset_source_pkg::OFF_IRQ_STATUS;
    wire sel_imask = paddr == reset_source_pkg::OFF_IRQ_MASK;
    wire mapped = sel_guard | sel_cause | sel_thresh | sel_wdg | sel_stat | sel_istat | sel_imask;

    ////////////////////////////////////////////////////////////////////////////
    // Guard decoding
    wire guard_bad = (guard_r != reset_source_pkg::GUARD_NOP_A)
                   && (guard_r != reset_source_pkg::GUARD_NOP_B);
    wire thresh_bad = !(thresh_r == reset_source_pkg::THRESH_2V10
                     || thresh_r == reset_source_pkg::THRESH_2V55
                     || thresh_r == reset_source_pkg::THRESH_3V15
                     || thresh_r == reset_source_pkg::THRESH_3V80);
    wire wdg_bad = (wdg_r[7:3] != reset_source_pkg::WDG_DISABLE)
                 && (wdg_r[7:3] != reset_source_pkg::WDG_ENABLE);
    wire any_bad = guard_bad | thresh_bad | wdg_bad;
    wire lv_watch = lv_s && !low_power_mode_i;
    wire pulse_busy = pulse_r != 4'h0;

    delay_count_if sw_dc();
    delay_count_if lv_dc();
    assign sw_dc.run = any_bad && !pulse_busy;
    assign lv_dc.run = lv_watch && !pulse_busy;

    delay_counter #(.CYCLES(SRESET_CYCLES)) u_sw_delay (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .dc(sw_dc)
    );
    delay_counter #(.CYCLES(LV_QUALIFY_CYCLES)) u_lv_delay (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .dc(lv_dc)
    );

    // A value repaired in the very cycle the delay expires no longer fires, so no flagless reset
    wire sw_fire = sw_dc.expired && any_bad && !pulse_busy;
    wire lv_fire = lv_dc.expired && !pulse_busy;
    wire to_rise = to_s && !to_prev_r;
    wire to_full = to_rise && !low_power_mode_i && !pulse_busy;
    wire to_core = to_rise && low_power_mode_i && !pulse_busy;
    wire full_fire = sw_fire | lv_fire | to_full;

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    logic [3:0] cause_set, cause_nxt;
    logic [reset_source_pkg::IRQ_BITS-1:0] irq_set, irq_nxt;
    assign cause_set[reset_source_pkg::FLAG_GUARD_WORD] = sw_fire && guard_bad;
    assign cause_set[reset_source_pkg::FLAG_LOW_VOLTAGE] = lv_fire;
    assign cause_set[reset_source_pkg::FLAG_THRESH_CORRUPT] = sw_fire && thresh_bad;
    assign cause_set[reset_source_pkg::FLAG_WATCHDOG_GUARD] = sw_fire && wdg_bad;
    // Set wins over a software clear in the same cycle
    assign cause_nxt = ((wr && sel_cause) ? (cause_r & pwdata[3:0]) : cause_r)
                     | cause_set;
    assign irq_set = {to_rise && !pulse_busy, lv_fire, sw_fire && wdg_bad,
                      sw_fire && thresh_bad, sw_fire && guard_bad};
    assign irq_nxt = ((wr && sel_istat) ? (irq_stat_r & ~pwdata[4:0]) : irq_stat_r) | irq_set;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            guard_r <= reset_source_pkg::GUARD_WORD_POR;
            thresh_r <= reset_source_pkg::THRESH_POR;
            wdg_r <= reset_source_pkg::WDG_CTRL_POR;
            cause_r <= 4'h0;
            stat_r <= 2'b00;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            to_prev_r <= 1'b0;
        end else if (clk_en_i) begin
            to_prev_r <= to_s;
            cause_r <= cause_nxt;
            irq_stat_r <= irq_nxt;
            if (wr && sel_imask) begin
                irq_mask_r <= pwdata[4:0];
            end
            if (full_fire) begin
                // Full reset reloads guard registers; a plain LOW_VOLTAGE_RESET keeps the selector
                guard_r <= reset_source_pkg::GUARD_WORD_POR;
                wdg_r <= reset_source_pkg::WDG_CTRL_POR;
                if (sw_fire && thresh_bad) begin
                    thresh_r <= reset_source_pkg::THRESH_POR;
                end
            end else begin
                if (wr && sel_guard) begin
                    guard_r <= pwdata[7:0];
                end
                if (wr && sel_thresh) begin
                    thresh_r <= pwdata[7:0];
                end
                if (wr && sel_wdg) begin
                    wdg_r <= pwdata[7:0];
                end
            end
            if (to_full) begin
                stat_r[reset_source_pkg::STAT_TIMEOUT] <= 1'b1;
            end else if (to_core) begin
                stat_r <= 2'b11;
            end else if (power_down_set_i) begin
                stat_r[reset_source_pkg::STAT_POWER_DOWN] <= 1'b1;
            end else if (wr && sel_stat) begin
                stat_r <= pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse generation
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_r <= 4'(reset_source_pkg::RESET_PULSE_CYCLES);
            kind_r <= reset_source_pkg::RST_FULL;
        end else if (clk_en_i) begin
            if (full_fire) begin
                pulse_r <= 4'(reset_source_pkg::RESET_PULSE_CYCLES);
                kind_r <= reset_source_pkg::RST_FULL;
            end else if (to_core) begin
                pulse_r <= 4'(reset_source_pkg::RESET_PULSE_CYCLES);
                kind_r <= reset_source_pkg::RST_CORE;
            end else if (pulse_busy) begin
                pulse_r <= pulse_r - 4'h1;
            end else begin
                kind_r <= reset_source_pkg::RST_NONE;
            end
        end
    end
    // Full reset drives PC, interrupts, timers, ports and stack in the core
    assign full_reset_o = pulse_busy && (kind_r == reset_source_pkg::RST_FULL);
    assign core_reset_o = pulse_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs and bus read
    assign threshold_level_o = (thresh_r == reset_source_pkg::THRESH_2V55) ? 2'h1 :
                               (thresh_r == reset_source_pkg::THRESH_3V15) ? 2'h2 :
                               (thresh_r == reset_source_pkg::THRESH_3V80) ? 2'h3 : 2'h0;
    assign low_voltage_enable_o = !low_power_mode_i;
    assign watchdog_enable_o = wdg_r[7:3] == reset_source_pkg::WDG_ENABLE;
    assign irq_o = |(irq_stat_r & irq_mask_r);
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    wire [31:0] rd_mux = sel_guard ? {24'h0, guard_r} :
                         sel_cause ? {28'h0, cause_r} :
                         sel_thresh ? {24'h0, thresh_r} :
                         sel_wdg ? {24'h0, wdg_r} :
                         sel_stat ? {30'h0, stat_r} :
                         sel_istat ? {27'h0, irq_stat_r} :
                         sel_imask ? {27'h0, irq_mask_r} : 32'h0;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata <= 32'h0;
        end else if (clk_en_i && psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_GUARD_NOP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (guard_r == 8'h55 || guard_r == 8'hAA) |-> !guard_bad)
        else $error("valid guard word flagged bad");
    AST_GUARD_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && sw_fire && guard_bad) |=> cause_r[3] && full_reset_o)
        else $error("guard word reset did not set flag");
    AST_FLAG_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && cause_r[2] && !(wr && sel_cause)) |=> cause_r[2])
        else $error("cause flag cleared without write");
    AST_UPPER_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (psel && penable && !pwrite && sel_cause) |-> prdata[31:4] == 28'h0)
        else $error("upper cause bits not zero");
    AST_LV_QUALIFY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(cause_r[2]) |-> $past(lv_dc.expired))
        else $error("low voltage flag without qualification");
    AST_THRESH_DEC: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        thresh_r == 8'h99 |-> threshold_level_o == 2'h2)
        else $error("threshold decode wrong");
    AST_THRESH_RELOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && sw_fire && thresh_bad) |=> thresh_r == 8'h55 && cause_r[1])
        else $error("corrupt selector not reloaded");
    AST_LV_KEEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && lv_fire && !sw_fire && !wr) |=> $stable(thresh_r))
        else $error("selector changed by low voltage reset");
    AST_LV_SLEEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        low_power_mode_i |-> !lv_dc.run)
        else $error("low voltage active in low power");
    AST_CORE_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && to_core && !full_fire) |=> core_reset_o && !full_reset_o && stat_r == 2'b11)
        else $error("low power timeout effect wrong");
    AST_TO_FULL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && to_full) |=> full_reset_o && stat_r[0])
        else $error("normal timeout effect wrong");
    COV_GUARD: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) sw_fire && guard_bad);
    COV_LV: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) lv_fire);
    COV_CORE: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) to_core);
endmodule
`default_nettype wire

// ===== test_reset_source_control.sv
// Testbench: reset source control driven over APB with pin-level event stimulus
`timescale 1ns/1ps
`default_nettype none
module test_reset_source_control;
    logic ref_clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
    logic low_supply_i, low_power_mode_i, wdt_timeout_i, power_down_set_i;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] threshold_level_o;
    logic low_voltage_enable_o, watchdog_enable_o, full_reset_o, core_reset_o, irq_o;
    logic [32:0] exp_q[$];
    logic [7:0] codes[4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
    int n_errors = 0;
    int n_checks = 0;
    integer seed = 32'hF640626A;

    // Short counts keep the run brief; the quiet windows and low-supply glitch lengths below are sized against them
    reset_source_control #(.SRESET_CYCLES(8), .LV_QUALIFY_CYCLES(16)) dut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_supply_i(low_supply_i), .low_power_mode_i(low_power_mode_i),
        .wdt_timeout_i(wdt_timeout_i), .power_down_set_i(power_down_set_i),
        .threshold_level_o(threshold_level_o), .low_voltage_enable_o(low_voltage_enable_o),
        .watchdog_enable_o(watchdog_enable_o), .full_reset_o(full_reset_o),
        .core_reset_o(core_reset_o), .irq_o(irq_o)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read results are compared against the oldest note as each access completes
    always @(posedge ref_clk_i) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk({pslverr, prdata}, 33'h1FFFFFFFF);
            end else begin
                chk({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int i;
        i = 0;
        if (!wr) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    // Waits for a reset pulse, checks its kind, then lets it finish
    task automatic wait_rst(input logic full_exp);
        int i;
        i = 0;
        while (core_reset_o !== 1'b1 && i < 100) begin
            @(posedge ref_clk_i);
            i++;
        end
        chk({32'h0, core_reset_o}, 33'h1);
        chk({32'h0, full_reset_o}, {32'h0, full_exp});
        while (core_reset_o === 1'b1 && i < 200) begin
            @(posedge ref_clk_i);
            i++;
        end
        chk({32'h0, core_reset_o}, 33'h0);
        @(posedge ref_clk_i);
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge ref_clk_i);
            if (core_reset_o === 1'b1) seen = 1'b1;
        end
        chk({32'h0, seen}, 33'h0);
    endtask

    function automatic logic [7:0] bad_val(input logic sel);
        logic [7:0] v;
        v = 8'h55;
        while (v == 8'h55 || v == 8'hAA || (sel && (v == 8'h33 || v == 8'h99))) begin
            v = 8'($random(seed));
        end
        return v;
    endfunction

    task automatic done(input string name);
        $display("test %s finished, checks=%0d", name, n_checks);
    endtask

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] g;
        rst_b_i = 1'b0;
        {psel, penable, pwrite, low_supply_i, low_power_mode_i, wdt_timeout_i} = 6'h00;
        power_down_set_i = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        wait_rst(1'b1);
        rd(reset_source_pkg::OFF_GUARD_WORD, 32'h55);
        rd(reset_source_pkg::OFF_THRESH_SEL, 32'h55);
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h0);
        rd(reset_source_pkg::OFF_STATUS, 32'h0);
        rd(reset_source_pkg::OFF_WDG_CTRL, 32'h53);
        apb(1'b0, 8'h1C, 32'h0, 33'h100000000);
        chk({32'h0, watchdog_enable_o}, 33'h1);
        done("power_on");
        for (int k = 0; k < 4; k++) begin
            wr(reset_source_pkg::OFF_THRESH_SEL, {24'h0, codes[k]});
            rd(reset_source_pkg::OFF_THRESH_SEL, {24'h0, codes[k]});
            chk({31'h0, threshold_level_o}, 33'(k));
        end
        quiet(12);
        wr(reset_source_pkg::OFF_GUARD_WORD, 32'hAA);
        quiet(20);
        wr(reset_source_pkg::OFF_GUARD_WORD, {24'h0, bad_val(1'b0)});
        wait_rst(1'b1);
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h08);
        rd(reset_source_pkg::OFF_GUARD_WORD, 32'h55);
        wr(reset_source_pkg::OFF_CAUSE_FLAGS, 32'hFF);
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h08);
        wr(reset_source_pkg::OFF_CAUSE_FLAGS, 32'hF7);
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h00);
        done("guard_word");
        wr(reset_source_pkg::OFF_THRESH_SEL, {24'h0, bad_val(1'b1)});
        wait_rst(1'b1);
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h02);
        rd(reset_source_pkg::OFF_THRESH_SEL, 32'h55);
        wr(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h0);
        wr(reset_source_pkg::OFF_WDG_CTRL, 32'hAB);
        chk({32'h0, watchdog_enable_o}, 33'h0);
        g = 5'h15;
        while (g == 5'h15 || g == 5'h0A) g = 5'($random(seed));
        wr(reset_source_pkg::OFF_WDG_CTRL, {24'h0, g, 3'b011});
        wait_rst(1'b1);
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h01);
        rd(reset_source_pkg::OFF_WDG_CTRL, 32'h53);
        wr(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h0);
        done("selector_and_watchdog_guard");
        // Power-down flag set first, so the normal timeout must leave it untouched
        power_down_set_i <= 1'b1;
        @(posedge ref_clk_i);
        power_down_set_i <= 1'b0;
        wdt_timeout_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        wdt_timeout_i <= 1'b0;
        wait_rst(1'b1);
        rd(reset_source_pkg::OFF_STATUS, 32'h03);
        wr(reset_source_pkg::OFF_STATUS, 32'h0);
        low_power_mode_i <= 1'b1;
        wdt_timeout_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        wdt_timeout_i <= 1'b0;
        wait_rst(1'b0);
        rd(reset_source_pkg::OFF_STATUS, 32'h03);
        chk({32'h0, irq_o}, 33'h0);
        wr(reset_source_pkg::OFF_IRQ_MASK, 32'h10);
        chk({32'h0, irq_o}, 33'h1);
        wr(reset_source_pkg::OFF_IRQ_STATUS, 32'h10);
        chk({32'h0, irq_o}, 33'h0);
        chk({32'h0, low_voltage_enable_o}, 33'h0);
        low_supply_i <= 1'b1;
        quiet(40);
        low_supply_i <= 1'b0;
        low_power_mode_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        chk({32'h0, low_voltage_enable_o}, 33'h1);
        done("timeout");
        wr(reset_source_pkg::OFF_THRESH_SEL, 32'h99);
        repeat (2) begin
            low_supply_i <= 1'b1;
            repeat (10) @(posedge ref_clk_i);
            low_supply_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
        quiet(30);
        low_supply_i <= 1'b1;
        wait_rst(1'b1);
        low_supply_i <= 1'b0;
        rd(reset_source_pkg::OFF_CAUSE_FLAGS, 32'h04);
        rd(reset_source_pkg::OFF_THRESH_SEL, 32'h99);
        rd(reset_source_pkg::OFF_STATUS, 32'h03);
        done("low_voltage");
        print_verdict();
    end

    // Whole run is a few hundred cycles; this margin only catches a hang
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
